// ===== verilog/gpp_pkg.sv
// gpp_pkg: constants for the general purpose io port
package gpp_pkg;
	localparam int          NPIN      = 8;
	localparam int          NGRP      = 2;
	localparam logic [11:0] OFF_DATA  = 12'h000;
	localparam logic [11:0] OFF_DIR   = 12'h004;
	localparam logic [11:0] OFF_OPT   = 12'h008;
	localparam logic [11:0] OFF_EDGE  = 12'h00C;
	localparam logic [11:0] OFF_GSEL  = 12'h010;
	localparam logic [11:0] OFF_PEND  = 12'h014;
	localparam logic [7:0]  RST_DATA  = 8'hFF;
	localparam logic [7:0]  RST_DIR   = 8'h00;
	localparam logic [7:0]  RST_OPT   = 8'h00;
	localparam logic [7:0]  RST_GSEL  = 8'h0F;
	localparam logic [1:0]  RST_EDGE  = 2'h0;
	localparam logic        EDGE_RISE = 1'h0;
	localparam logic        EDGE_FALL = 1'h1;
	localparam logic [23:0] ZERO_PAD  = 24'h000000;
	localparam logic [29:0] ZERO_PAD2 = 30'h00000000;
	typedef enum logic [1:0] {
		GPP_IDLE   = 2'b00,
		GPP_ACCESS = 2'b01
	} gpp_bus_state_t;
endpackage

// ===== verilog/gpp_cfg_if.sv
// gpp_cfg_if: port configuration carried from the bus slave to the pin logic
`timescale 1ns/100ps
interface gpp_cfg_if;
	logic [7:0] data_latch;
	logic [7:0] dir;
	logic [7:0] opt;
	logic [7:0] pin_in;
	logic [7:0] irq_in;
	modport owner (output data_latch, output dir, output opt, input pin_in, input irq_in);
	modport pins  (input data_latch, input dir, input opt, output pin_in, output irq_in);
endinterface

// ===== verilog/gpp_pin_cell.sv
// gpp_pin_cell: per pin drive, pull, read back and interrupt level logic
`timescale 1ns/100ps
module gpp_pin_cell (
	input  wire logic       clk,
	input  wire logic       rst_n,
	gpp_cfg_if.pins         cfg,
	input  wire logic [7:0] pad_in,
	input  wire logic [7:0] alt_oe,
	input  wire logic [7:0] alt_out,
	output logic      [7:0] pad_out,
	output logic      [7:0] pad_oe,
	output logic      [7:0] pull_en,
	output logic      [7:0] alt_in
);
	logic [7:0] sync1_reg;
	logic [7:0] sync2_reg;

	// two stage synchroniser; only sync2 is read
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_reg <= 8'h00;
			sync2_reg <= 8'h00;
		end else begin
			sync1_reg <= pad_in;
			sync2_reg <= sync1_reg;
		end
	end

	genvar i;
	generate
		for (i = 0; i < gpp_pkg::NPIN; i++) begin : g_pin
			wire out_mode = cfg.dir[i] | alt_oe[i];
			wire drv_val  = alt_oe[i] ? alt_out[i] : cfg.data_latch[i];
			wire push     = alt_oe[i] | cfg.opt[i];
			assign pad_out[i] = drv_val;
			// open drain drives only a zero; push pull both levels
			assign pad_oe[i]  = out_mode & (push | ~drv_val);
			assign pull_en[i] = ~out_mode & cfg.opt[i];
			// read: input mode gives pin, except alt drive; output mode gives latch
			assign cfg.pin_in[i] = cfg.dir[i] ? cfg.data_latch[i] :
				(alt_oe[i] ? alt_out[i] : sync2_reg[i]);
			assign alt_in[i] = cfg.dir[i] ? cfg.data_latch[i] : sync2_reg[i];
			// a disabled interrupt pin presents a one to the edge detector
			assign cfg.irq_in[i] = (~cfg.dir[i] & cfg.opt[i]) ? sync2_reg[i] : 1'b1;
		end
	endgenerate
endmodule

// ===== verilog/gpp_port.sv
// gpp_port: eight pin general purpose io port with apb registers and external interrupt lines
// How it works
// - eight pins; bit x of data, direction, option controls pin x
// - direction 0 makes an input; data read returns the pin level
// - in input mode option selects floating or pull-up
// - data writes in input mode only change the latch
// - option set in input mode makes the pin an interrupt source
// - each interrupt line has its own rising or falling sensitivity
// - pins of a group are ANDed before edge detection
// - a vector fetch clears that line's pending request
// - changing a line's sensitivity clears its pending request
// - disabled interrupt pins feed logic one to the detector
// - direction 1 drives latch; read returns written value
// - option selects push-pull or open-drain output drive
// - enabled peripheral output forces output and overrides port settings
// - input pin driven by alternate output reads alternate value
// - output pin gives alternate input the data latch value
// - direction/option pairs: 00 float, 01 pull-up, 10 open drain, 11 push-pull
`timescale 1ns/100ps
module gpp_port (
	input  wire logic        SYS_CLK,
	input  wire logic        RESETN,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic [7:0]  PAD_IN,
	output logic      [7:0]  PAD_OUT,
	output logic      [7:0]  PAD_OE,
	output logic      [7:0]  PULL_EN,
	input  wire logic [7:0]  ALT_OE,
	input  wire logic [7:0]  ALT_OUT,
	output logic      [7:0]  ALT_IN,
	input  wire logic [1:0]  VECTOR_FETCH,
	output logic      [1:0]  EXT_IRQ
);
	gpp_cfg_if cfg ();

	logic [7:0]  data_reg;
	logic [7:0]  dir_reg;
	logic [7:0]  opt_reg;
	logic [1:0]  edge_reg;
	logic [7:0]  gsel_reg;
	logic [1:0]  pend_reg;
	logic [1:0]  pend_next;
	logic [1:0]  grp_lvl_reg;
	logic [31:0] prdata_reg;
	logic        pready_reg;
	logic        pslverr_reg;
	logic [7:0]  pad_out_reg;
	logic [7:0]  pad_oe_reg;
	logic [7:0]  pull_en_reg;
	logic [7:0]  alt_in_reg;
	wire  [7:0]  pad_out_w;
	wire  [7:0]  pad_oe_w;
	wire  [7:0]  pull_en_w;
	wire  [7:0]  alt_in_w;

	assign cfg.data_latch = data_reg;
	assign cfg.dir        = dir_reg;
	assign cfg.opt        = opt_reg;

	gpp_pin_cell u_cell (
		.clk     (SYS_CLK),
		.rst_n   (RESETN),
		.cfg     (cfg),
		.pad_in  (PAD_IN),
		.alt_oe  (ALT_OE),
		.alt_out (ALT_OUT),
		.pad_out (pad_out_w),
		.pad_oe  (pad_oe_w),
		.pull_en (pull_en_w),
		.alt_in  (alt_in_w)
	);

	// apb decode; single wait-free access, unmapped gives pslverr
	wire        setup   = PSEL & ~PENABLE;
	// a write lands only on the completing edge, so a setup that is never finished changes nothing
	wire        acc_done = PSEL & PENABLE & pready_reg;
	wire        wr_en   = acc_done & PWRITE;
	wire        hit_dat = PADDR == gpp_pkg::OFF_DATA;
	wire        hit_dir = PADDR == gpp_pkg::OFF_DIR;
	wire        hit_opt = PADDR == gpp_pkg::OFF_OPT;
	wire        hit_edg = PADDR == gpp_pkg::OFF_EDGE;
	wire        hit_gs  = PADDR == gpp_pkg::OFF_GSEL;
	wire        hit_pnd = PADDR == gpp_pkg::OFF_PEND;
	wire        mapped  = hit_dat | hit_dir | hit_opt | hit_edg | hit_gs | hit_pnd;
	wire [7:0]  rd8     = hit_dat ? cfg.pin_in : hit_dir ? dir_reg : hit_opt ? opt_reg :
		hit_gs ? gsel_reg : 8'h00;
	wire [31:0] rdata   = hit_edg ? {gpp_pkg::ZERO_PAD2, edge_reg} :
		hit_pnd ? {gpp_pkg::ZERO_PAD2, pend_reg} : {gpp_pkg::ZERO_PAD, rd8};
	wire [1:0]  edge_wr = PWDATA[1:0];
	wire        edge_ch = wr_en & hit_edg; // write strobe for sensitivity

	// answer registered in the setup cycle, so pready rises with penable
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			prdata_reg  <= 32'h00000000;
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg  <= setup;
			pslverr_reg <= setup & ~mapped;
			prdata_reg  <= (setup & ~PWRITE) ? rdata : 32'h00000000;
		end
	end

	// config registers; a data write only updates the latch
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			data_reg <= gpp_pkg::RST_DATA;
			dir_reg  <= gpp_pkg::RST_DIR;
			opt_reg  <= gpp_pkg::RST_OPT;
			gsel_reg <= gpp_pkg::RST_GSEL;
			edge_reg <= gpp_pkg::RST_EDGE;
		end else begin
			if (wr_en && hit_dat)
				data_reg <= PWDATA[7:0];
			if (wr_en && hit_dir)
				dir_reg <= PWDATA[7:0];
			if (wr_en && hit_opt)
				opt_reg <= PWDATA[7:0];
			if (wr_en && hit_gs)
				gsel_reg <= PWDATA[7:0];
			if (edge_ch)
				edge_reg <= edge_wr;
		end
	end

	// group combine: AND of member pins; gsel bit 1 puts a pin on line 0
	wire [7:0] grp0_term = cfg.irq_in | ~gsel_reg;
	wire [7:0] grp1_term = cfg.irq_in | gsel_reg;
	wire [1:0] grp_lvl   = {&grp1_term, &grp0_term};

	genvar g;
	generate
		for (g = 0; g < gpp_pkg::NGRP; g++) begin : g_line
			wire rise = grp_lvl[g] & ~grp_lvl_reg[g];
			wire fall = ~grp_lvl[g] & grp_lvl_reg[g];
			wire hit  = (edge_reg[g] == gpp_pkg::EDGE_FALL) ? fall : rise;
			wire clr  = VECTOR_FETCH[g] | (edge_ch && (edge_wr[g] != edge_reg[g]));
			// a new edge wins over a clear in the same cycle
			assign pend_next[g] = hit | (pend_reg[g] & ~clr);
		end
	endgenerate

	// detector history resets to one, matching a disabled pin
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			grp_lvl_reg <= {gpp_pkg::NGRP{1'b1}};
			pend_reg    <= 2'h0;
		end else begin
			grp_lvl_reg <= grp_lvl;
			pend_reg    <= pend_next;
		end
	end

	// pin outputs registered to keep top outputs on flops
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			pad_out_reg <= 8'h00;
			pad_oe_reg  <= 8'h00;
			pull_en_reg <= 8'h00;
			alt_in_reg  <= 8'h00;
		end else begin
			pad_out_reg <= pad_out_w;
			pad_oe_reg  <= pad_oe_w;
			pull_en_reg <= pull_en_w;
			alt_in_reg  <= alt_in_w;
		end
	end

	assign PRDATA  = prdata_reg;
	assign PREADY  = pready_reg;
	assign PSLVERR = pslverr_reg;
	assign PAD_OUT = pad_out_reg;
	assign PAD_OE  = pad_oe_reg;
	assign PULL_EN = pull_en_reg;
	assign ALT_IN  = alt_in_reg;
	assign EXT_IRQ = pend_reg;

	// assertions
	sequence fetch_s(int n);
		VECTOR_FETCH[n] && !(g_line[0].hit && n == 0) && !(g_line[1].hit && n == 1);
	endsequence

	fetch_clear_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		fetch_s(0) |=> !EXT_IRQ[0])
		else $error("fetch did not clear line 0");
	sens_clear_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		(edge_ch && edge_wr[1] != edge_reg[1] && !g_line[1].hit) |=> !EXT_IRQ[1])
		else $error("sensitivity change kept line 1 pending");
	rise_set_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		(edge_reg[0] == gpp_pkg::EDGE_RISE && grp_lvl[0] && !grp_lvl_reg[0]) |=> EXT_IRQ[0])
		else $error("rising edge missed");
	disabled_one_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		(opt_reg == 8'h00) |-> (cfg.irq_in == 8'hFF))
		else $error("disabled pin not forced high");
	input_noout_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		(dir_reg == 8'h00 && ALT_OE == 8'h00) |=> (PAD_OE == 8'h00))
		else $error("input pin driven");
	out_read_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		(setup && !PWRITE && hit_dat && dir_reg == 8'hFF) |=> (PRDATA[7:0] == $past(data_reg)))
		else $error("output read not latch");
	od_float_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		(dir_reg[0] && !opt_reg[0] && !ALT_OE[0] && data_reg[0]) |=> !PAD_OE[0])
		else $error("open drain drove high");
	pull_sel_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		(!dir_reg[0] && !ALT_OE[0]) |=> (PULL_EN[0] == $past(opt_reg[0])))
		else $error("pull enable wrong");

	// bus steps used by the read-back and write checks
	sequence rd_setup_s(logic [11:0] a);
		setup && !PWRITE && PADDR == a;
	endsequence

	sequence wr_done_s;
		wr_en;
	endsequence

	// bus answer checks
	ready_follows_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		setup |=> PREADY)
		else $error("ready missing after setup");

	ready_single_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		PREADY |=> !PREADY)
		else $error("ready held too long");

	unmapped_err_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		(setup && !mapped) |=> (PREADY && PSLVERR))
		else $error("unmapped access without error");

	unmapped_keep_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		(wr_done_s ##0 !mapped) |=> ($stable(data_reg) && $stable(dir_reg) && $stable(opt_reg)))
		else $error("unmapped write changed a register");

	upper_zero_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		PREADY |-> (PRDATA[31:8] == 24'h000000))
		else $error("upper read bits not zero");

	data_write_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		(wr_done_s ##0 hit_dat) |=> (data_reg == $past(PWDATA[7:0])))
		else $error("data write missed the latch");

	in_read_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		(rd_setup_s(gpp_pkg::OFF_DATA) ##0 (!dir_reg[0] && !ALT_OE[0]))
		|=> (PRDATA[0] == $past(PAD_IN[0], 3)))
		else $error("input read not pin level");

	dir_read_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		rd_setup_s(gpp_pkg::OFF_DIR) |=> (PRDATA[7:0] == $past(dir_reg)))
		else $error("direction read back wrong");

	opt_read_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		rd_setup_s(gpp_pkg::OFF_OPT) |=> (PRDATA[7:0] == $past(opt_reg)))
		else $error("option read back wrong");

	pend_read_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		rd_setup_s(gpp_pkg::OFF_PEND) |=> (PRDATA[1:0] == $past(pend_reg)))
		else $error("pending read back wrong");

	// pin drive checks on pin zero; the other pins share the same generate body
	push_drive_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		(dir_reg[0] && opt_reg[0] && !ALT_OE[0]) |=> (PAD_OE[0] && PAD_OUT[0] == $past(data_reg[0])))
		else $error("push pull drive wrong");

	od_low_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		(dir_reg[0] && !opt_reg[0] && !ALT_OE[0] && !data_reg[0]) |=> (PAD_OE[0] && !PAD_OUT[0]))
		else $error("open drain did not pull low");

	out_nopull_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		dir_reg[0] |=> !PULL_EN[0])
		else $error("pull-up on an output");

	alt_force_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		ALT_OE[0] |=> (PAD_OE[0] && PAD_OUT[0] == $past(ALT_OUT[0])))
		else $error("peripheral drive not forced");

	alt_read_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		(rd_setup_s(gpp_pkg::OFF_DATA) ##0 (!dir_reg[0] && ALT_OE[0]))
		|=> (PRDATA[0] == $past(ALT_OUT[0])))
		else $error("input read not peripheral value");

	alt_latch_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		dir_reg[0] |=> (ALT_IN[0] == $past(data_reg[0])))
		else $error("peripheral input not latch");

	// interrupt line checks
	fall_set_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		(edge_reg[0] == gpp_pkg::EDGE_FALL && !grp_lvl[0] && grp_lvl_reg[0]) |=> EXT_IRQ[0])
		else $error("falling edge missed");

	rise_ignored_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		(edge_reg[0] == gpp_pkg::EDGE_FALL && grp_lvl[0] && !grp_lvl_reg[0] && !EXT_IRQ[0]) |=> !EXT_IRQ[0])
		else $error("rising edge taken on falling line");

	group_mask_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		(gsel_reg[0] && !cfg.irq_in[0]) |-> !grp_lvl[0])
		else $error("low pin did not mask its group");

	pend_hold_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		(EXT_IRQ[0] && !VECTOR_FETCH[0] && !edge_ch) |=> EXT_IRQ[0])
		else $error("pending request lost without fetch");
endmodule

// ===== bench/gpp_pins_model.sv
// gpp_pins_model: outside circuitry seen by the eight port pads
`timescale 1ns/100ps
module gpp_pins_model (
	input  wire logic       clk,
	input  wire logic [7:0] pad_out,
	input  wire logic [7:0] pad_oe,
	input  wire logic [7:0] pull_en,
	input  wire logic [7:0] ext_en,
	input  wire logic [7:0] ext_val,
	output logic      [7:0] pad_in
);
	logic [7:0] float_reg = 8'h00;
	// an undriven pad wanders every cycle so a floating read is never trusted
	always @(posedge clk) begin
		float_reg <= ~pad_in;
	end
	// port drive wins, then the outside driver, then the pull-up
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val) | (~pad_oe & ~ext_en & (pull_en | float_reg));
endmodule

// ===== bench/gpp_port_bench.sv
// gpp_port_bench: self-checking bench of the io port
`timescale 1ns/100ps
module gpp_port_bench;
	logic        sys_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000, prdata, seed = 32'h00002368, r;
	logic        pready, pslverr;
	logic [7:0]  pad_in, pad_out, pad_oe, pull_en, alt_in, ext_en = 8'h00, ext_val = 8'h00, alt_oe = 8'h00, alt_out = 8'h00;
	logic [1:0]  vf = 2'h0, irq;
	logic [33:0] exp_q[$];
	logic [33:0] e;
	int          fails = 0, tests_run = 0;
	always #2 sys_clk = ~sys_clk;
	gpp_port gpp_port_i (.SYS_CLK(sys_clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PAD_IN(pad_in),
		.PAD_OUT(pad_out), .PAD_OE(pad_oe), .PULL_EN(pull_en), .ALT_OE(alt_oe), .ALT_OUT(alt_out),
		.ALT_IN(alt_in), .VECTOR_FETCH(vf), .EXT_IRQ(irq));
	gpp_pins_model gpp_pins_model_i (.clk(sys_clk), .pad_out(pad_out), .pad_oe(pad_oe), .pull_en(pull_en),
		.ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		tests_run++;
		if (g !== x) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, x, g);
		end
	endtask
	// bus answers: error flag and read data
	task automatic chk_bus(input string nm, input logic [31:0] x, input logic [31:0] g);
		chk(nm, x, g);
	endtask
	// one apb transfer; the expected answer is queued for the monitor
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic err);
		int n;
		n = 0;
		@(posedge sys_clk);
		exp_q.push_back({~w, err, d});
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1 && ++n < 20);
		if (n >= 20) fails++;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h000000, d}, 1'b0);
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] x);
		apb(1'b0, a, {24'h000000, x}, 1'b0);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic pins(input logic [7:0] en, input logic [7:0] v);
		@(posedge sys_clk);
		ext_en <= en;
		ext_val <= v;
		wt(6);
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// monitor: each answer is matched against the oldest queued note
	always @(posedge sys_clk) begin
		if (psel && penable && pready === 1'b1) begin
			e = exp_q.pop_front();
			chk_bus("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
			if (e[33]) chk_bus("prdata", e[31:0], prdata);
		end
	end
	// watchdog far beyond the few hundred cycles the tests need
	initial begin
		#200000;
		fails++;
		conclude();
	end
	initial begin
		repeat (10) @(posedge sys_clk);
		resetn <= 1'b1;
		rd(gpp_pkg::OFF_DIR, gpp_pkg::RST_DIR);
		rd(gpp_pkg::OFF_OPT, gpp_pkg::RST_OPT);
		rd(gpp_pkg::OFF_GSEL, gpp_pkg::RST_GSEL);
		rd(gpp_pkg::OFF_EDGE, 8'h00);
		apb(1'b1, 12'h018, 32'h000000FF, 1'b1);
		apb(1'b0, 12'h018, 32'h00000000, 1'b1);
		$display("test reset done");
		r = rnd();
		pins(8'hFF, r[7:0]);
		rd(gpp_pkg::OFF_DATA, r[7:0]);
		wr(gpp_pkg::OFF_DATA, 8'h5A);
		wt(3);
		chk("pad_oe", 32'h0, 32'(pad_oe));
		pins(8'hFF, 8'hFF);
		wr(gpp_pkg::OFF_OPT, 8'hFF);
		pins(8'h00, 8'h00);
		chk("pull_en", 32'hFF, 32'(pull_en));
		rd(gpp_pkg::OFF_DATA, 8'hFF);
		wr(gpp_pkg::OFF_OPT, 8'h00);
		$display("test input done");
		wr(gpp_pkg::OFF_DIR, 8'hFF);
		wr(gpp_pkg::OFF_OPT, 8'hFF);
		wt(3);
		chk("pad_oe", 32'hFF, 32'(pad_oe));
		chk("pad_out", 32'h5A, 32'(pad_out));
		chk("alt_in", 32'h5A, 32'(alt_in));
		rd(gpp_pkg::OFF_DATA, 8'h5A);
		r = rnd();
		wr(gpp_pkg::OFF_DATA, r[7:0]);
		wr(gpp_pkg::OFF_OPT, 8'h00);
		wt(3);
		chk("pad_oe", {24'h000000, ~r[7:0]}, 32'(pad_oe));
		chk("pad_low", 32'h0, 32'(pad_out & pad_oe));
		$display("test output done");
		wr(gpp_pkg::OFF_DIR, 8'h00);
		r = rnd();
		@(posedge sys_clk);
		alt_oe <= 8'hFF;
		alt_out <= r[7:0];
		wt(3);
		chk("pad_out", 32'(r[7:0]), 32'(pad_out & pad_oe));
		rd(gpp_pkg::OFF_DATA, r[7:0]);
		@(posedge sys_clk);
		alt_oe <= 8'h00;
		$display("test alternate done");
		pins(8'hFF, 8'hFF);
		for (int g = 0; g < 2; g++) begin
			wr(gpp_pkg::OFF_OPT, 8'h01 << (4 * g));
			pins(8'hFF, ~(8'h01 << (4 * g)));
			chk("ext_irq", 32'h0, 32'(irq));
			pins(8'hFF, 8'hFF);
			chk("ext_irq", 32'(2'b01 << g), 32'(irq));
			rd(gpp_pkg::OFF_PEND, 8'(2'b01 << g));
			@(posedge sys_clk);
			vf <= 2'b01 << g;
			@(posedge sys_clk);
			vf <= 2'b00;
			wt(2);
			chk("ext_irq", 32'h0, 32'(irq));
		end
		wr(gpp_pkg::OFF_OPT, 8'h01);
		wr(gpp_pkg::OFF_EDGE, 8'h01);
		pins(8'hFF, 8'hFE);
		chk("ext_irq", 32'h1, 32'(irq));
		wr(gpp_pkg::OFF_EDGE, 8'h00);
		wt(2);
		chk("ext_irq", 32'h0, 32'(irq));
		pins(8'hFF, 8'hFC);
		wr(gpp_pkg::OFF_OPT, 8'h03);
		pins(8'hFF, 8'hFD);
		chk("ext_irq", 32'h0, 32'(irq));
		pins(8'hFF, 8'hFE);
		wr(gpp_pkg::OFF_OPT, 8'h00);
		wt(4);
		chk("ext_irq", 32'h1, 32'(irq));
		// safe enable and disable with the pin held low must not raise a request
		@(posedge sys_clk);
		vf <= 2'b01;
		@(posedge sys_clk);
		vf <= 2'b00;
		wr(gpp_pkg::OFF_OPT, 8'h01);
		wt(2);
		chk("ext_irq", 32'h0, 32'(irq));
		wr(gpp_pkg::OFF_EDGE, 8'h01);
		wr(gpp_pkg::OFF_OPT, 8'h00);
		wr(gpp_pkg::OFF_EDGE, 8'h00);
		wt(2);
		chk("ext_irq", 32'h0, 32'(irq));
		$display("test interrupt done");
		wt(4);
		conclude();
	end
endmodule
